// ===== rtl/orp_image_mem.sv
/*
  Image memory holding the bytes to be programmed. Read data leave a register one
  cycle after the address. Assumes the clock is shared with the sequencer.
*/
`timescale 1ns/1ps
module orp_image_mem #(
  parameter int ADDR_W = orp_pkg::ADDR_W,
  parameter int DATA_W = orp_pkg::DATA_W
) (
  input wire logic clock_in,   // System clock
  orp_mem_if.mem port_if       // Access from the sequencer
);
  logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rd_q;

  // No reset on the array: contents are only meaningful after a load
  always_ff @(posedge clock_in) begin
    if (port_if.wr_en) begin
      store[port_if.wr_addr] <= port_if.wr_data;
    end
    rd_q <= store[port_if.rd_addr];
  end

  assign port_if.rd_data = rd_q;
endmodule

// ===== rtl/orp_mem_if.sv
/*
  Carrier between the sequencer and its image memory: one write port and one
  registered read port. Assumes both ends share the sequencer clock.
*/
`timescale 1ns/1ps
interface orp_mem_if #(
  parameter int ADDR_W = orp_pkg::ADDR_W,
  parameter int DATA_W = orp_pkg::DATA_W
);
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
               output rd_data);
endinterface

// ===== rtl/orp_pkg.sv
/*
  Constants, timing counts and state codes for the one-time programmable ROM
  programmer. Assumes a 50 MHz system clock; all times are converted to cycles here.
*/
// Function
// - Start session at the lowest address
// - Raise core 6.5V, programming 13.0V first
// - First pass: one pulse each, no read
// - Then verify-and-reprogram loop, address by address
// - On mismatch pulse again, max ten, reread
// - Still wrong after ten: stop, part failed
// - Match advances address; finish after all checked
// - After verify, lower both supplies to 5.0V
// - Reread all at 5.0V; pass if all match
// - Program pulse on chip select 95-105 us
// - Hold id pin at 11.5-12.5V for codes
package orp_pkg;
  localparam int CLK_PERIOD_NS = 20;          // 50 MHz
  localparam int NS_PER_US = 1000;
  localparam int ADDR_W = 15;                 // 32K locations
  localparam int DATA_W = 8;
  localparam int TIMER_W = 16;
  localparam int RETRY_W = 4;
  localparam logic [RETRY_W-1:0] RETRY_MAX = 4'hA;  // Ten extra pulses
  localparam int SYNC_STAGES = 3;
  // Times as printed
  localparam int T_SETUP_US = 2;              // Address, data, OE, supply setup and hold
  localparam int T_PW_NOM_US = 100;
  localparam int T_PW_MIN_US = 95;
  localparam int T_PW_MAX_US = 105;
  localparam int T_OE_NS = 150;               // Data valid after OE
  localparam int T_DFP_NS = 130;              // Output float after OE high
  // Derived cycle counts: least times round up, longest times round down
  localparam int SETUP_CYC = (T_SETUP_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PW_NOM_CYC = (T_PW_NOM_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int PW_MIN_CYC = (T_PW_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PW_MAX_CYC = (T_PW_MAX_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int OE_CYC = (T_OE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (T_DFP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Read wait also covers the input synchroniser and its agreement stage
  localparam int READ_CYC = OE_CYC + SYNC_STAGES + 1;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h00,
    ST_RAMP_UP  = 5'h01,
    ST_P1_SET   = 5'h02,
    ST_P1_PULSE = 5'h03,
    ST_P1_HOLD  = 5'h04,
    ST_V_FLOAT  = 5'h05,
    ST_V_READ   = 5'h06,
    ST_V_CMP    = 5'h07,
    ST_V_SET    = 5'h08,
    ST_V_GAP    = 5'h09,
    ST_V_PULSE  = 5'h0A,
    ST_V_HOLD   = 5'h0B,
    ST_RAMP_DN  = 5'h0C,
    ST_F_READ   = 5'h0D,
    ST_F_CMP    = 5'h0E,
    ST_ID_SET   = 5'h10,
    ST_ID_READ  = 5'h11
  } orp_state_type;
endpackage

// ===== rtl/orp_programmer.sv
/*
  Programming sequencer that drives a 32K x 8 one-time programmable ROM through its
  pins: first pass pulses, verify/reprogram loop, supply lowering and final
  read-back, plus reading the identification codes. Assumes external switches
  turn the supply selects into real voltages and the id pin select into 12 V.
*/
`timescale 1ns/1ps
module orp_programmer #(
  parameter int ADDR_W = orp_pkg::ADDR_W,
  parameter int PULSE_CYC = orp_pkg::PW_NOM_CYC,     // Program pulse length
  parameter int PULSE_MIN_CYC = orp_pkg::PW_MIN_CYC, // Pulse lower limit
  parameter int PULSE_MAX_CYC = orp_pkg::PW_MAX_CYC  // Pulse upper limit
) (
  input wire logic clock_in,                         // System clock
  input wire logic rstn_in,                          // Synchronous reset, low
  input wire logic load_valid_in,                    // Image byte offered
  input wire logic [ADDR_W-1:0] load_addr_in,        // Image byte address
  input wire logic [orp_pkg::DATA_W-1:0] load_data_in, // Image byte value
  output logic load_ready_out,                       // Image write accepted
  input wire logic start_in,                         // Start programming
  input wire logic id_read_in,                       // Start code read
  input wire logic id_sel_in,                        // 0 maker, 1 type code
  output logic busy_out,                             // Sequence running
  output logic done_out,                             // One-cycle session end pulse
  output logic pass_out,                             // Last session passed
  output logic fail_out,                             // Last session failed
  output logic [ADDR_W-1:0] fail_addr_out,           // Failing location
  output logic [orp_pkg::DATA_W-1:0] id_data_out,    // Captured code
  output logic [ADDR_W-1:0] rom_addr_out,            // ROM address pins
  output logic rom_ce_n_out,                         // Chip select, low
  output logic rom_oe_n_out,                         // Output enable, low
  output logic [orp_pkg::DATA_W-1:0] data_outputs_out, // Data pin drive
  output logic data_outputs_oe_out,                  // Data pin enable
  input wire logic [orp_pkg::DATA_W-1:0] data_outputs_in, // Data pin level
  output logic vcc_prog_out,                         // 1: core 6.5V, 0: 5.0V
  output logic vpp_prog_out,                         // 1: 13.0V, 0: 5.0V
  output logic id_mode_address_pin_hv_out            // Id pin at 12V
);
  localparam int DW = orp_pkg::DATA_W;
  localparam logic [ADDR_W-1:0] ADDR_LAST = {ADDR_W{1'b1}};
  localparam logic [orp_pkg::TIMER_W-1:0] T_SETUP = orp_pkg::TIMER_W'(orp_pkg::SETUP_CYC - 1);
  localparam logic [orp_pkg::TIMER_W-1:0] T_PULSE = orp_pkg::TIMER_W'(PULSE_CYC - 1);
  localparam logic [orp_pkg::TIMER_W-1:0] T_READ = orp_pkg::TIMER_W'(orp_pkg::READ_CYC - 1);
  localparam logic [orp_pkg::TIMER_W-1:0] T_FLOAT = orp_pkg::TIMER_W'(orp_pkg::FLOAT_CYC - 1);

  orp_pkg::orp_state_type state, next_state;
  logic [orp_pkg::TIMER_W-1:0] timer, next_timer;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [orp_pkg::RETRY_W-1:0] retry, next_retry;
  logic [DW-1:0] sync1, sync2, sync3, rd_byte;
  logic ce_n, oe_n, drive, pass, fail, done;
  logic [ADDR_W-1:0] fail_addr;
  logic [DW-1:0] id_data;
  logic [orp_pkg::TIMER_W-1:0] pulse_len;

  orp_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DW)) mem_if ();

  orp_image_mem #(.ADDR_W(ADDR_W), .DATA_W(DW)) u_mem (
    .clock_in(clock_in),
    .port_if(mem_if)
  );

  // Decode of pin activity and status from the state
  function automatic logic in_prog(input orp_pkg::orp_state_type s);
    in_prog = (s inside {orp_pkg::ST_RAMP_UP, orp_pkg::ST_P1_SET, orp_pkg::ST_P1_PULSE,
                         orp_pkg::ST_P1_HOLD, orp_pkg::ST_V_FLOAT, orp_pkg::ST_V_READ,
                         orp_pkg::ST_V_CMP, orp_pkg::ST_V_SET, orp_pkg::ST_V_GAP,
                         orp_pkg::ST_V_PULSE, orp_pkg::ST_V_HOLD});
  endfunction

  function automatic logic is_pulse(input orp_pkg::orp_state_type s);
    is_pulse = (s == orp_pkg::ST_P1_PULSE) || (s == orp_pkg::ST_V_PULSE);
  endfunction

  function automatic logic is_read(input orp_pkg::orp_state_type s);
    is_read = (s inside {orp_pkg::ST_V_READ, orp_pkg::ST_F_READ, orp_pkg::ST_ID_READ});
  endfunction

  wire idle = (state == orp_pkg::ST_IDLE);
  wire tick = (timer == '0);
  wire last_addr = (addr == ADDR_LAST);
  wire match = (rd_byte == mem_if.rd_data);
  wire next_ce_n = !(is_pulse(next_state) || is_read(next_state));
  wire next_oe_n = !is_read(next_state);
  wire next_drive = next_state inside {orp_pkg::ST_P1_SET, orp_pkg::ST_P1_PULSE,
                                       orp_pkg::ST_P1_HOLD, orp_pkg::ST_V_SET,
                                       orp_pkg::ST_V_PULSE, orp_pkg::ST_V_HOLD};

  // Image port: loads only while idle so the image cannot change mid-session
  assign load_ready_out = idle;
  assign mem_if.wr_en = load_valid_in && idle;
  assign mem_if.wr_addr = load_addr_in;
  assign mem_if.wr_data = load_data_in;
  assign mem_if.rd_addr = addr;

  // Sequencer; every wait state leaves when the timer has run out
  always_comb begin
    next_state = state;
    next_timer = tick ? timer : timer - 1'b1;
    next_addr = addr;
    next_retry = retry;
    case (state)
      orp_pkg::ST_IDLE: begin
        if (start_in) begin
          next_state = orp_pkg::ST_RAMP_UP;
          next_addr = '0;
          next_retry = '0;
          next_timer = T_SETUP;
        end else if (id_read_in) begin
          next_state = orp_pkg::ST_ID_SET;
          next_addr = ADDR_W'(id_sel_in);
          next_timer = T_SETUP;
        end
      end
      orp_pkg::ST_RAMP_UP: if (tick) begin
        next_state = orp_pkg::ST_P1_SET;
        next_timer = T_SETUP;
      end
      orp_pkg::ST_P1_SET: if (tick) begin
        next_state = orp_pkg::ST_P1_PULSE;
        next_timer = T_PULSE;
      end
      orp_pkg::ST_P1_PULSE: if (tick) begin
        next_state = orp_pkg::ST_P1_HOLD;
        next_timer = T_SETUP;
      end
      orp_pkg::ST_P1_HOLD: if (tick) begin
        next_timer = T_SETUP;
        if (last_addr) begin
          next_state = orp_pkg::ST_V_FLOAT;
          next_addr = '0;
        end else begin
          next_state = orp_pkg::ST_P1_SET;
          next_addr = addr + 1'b1;
        end
      end
      orp_pkg::ST_V_FLOAT: if (tick) begin
        next_state = orp_pkg::ST_V_READ;
        next_timer = T_READ;
      end
      orp_pkg::ST_V_READ: if (tick) begin
        next_state = orp_pkg::ST_V_CMP;
      end
      orp_pkg::ST_V_CMP: begin
        if (match) begin
          next_retry = '0;
          next_timer = T_SETUP;
          if (last_addr) begin
            next_state = orp_pkg::ST_RAMP_DN;
          end else begin
            next_state = orp_pkg::ST_V_FLOAT;
            next_addr = addr + 1'b1;
          end
        end else if (retry == orp_pkg::RETRY_MAX) begin
          next_state = orp_pkg::ST_IDLE;
        end else begin
          next_state = orp_pkg::ST_V_GAP;
          next_retry = retry + 1'b1;
          next_timer = T_FLOAT;
        end
      end
      orp_pkg::ST_V_GAP: if (tick) begin
        next_state = orp_pkg::ST_V_SET;
        next_timer = T_SETUP;
      end
      orp_pkg::ST_V_SET: if (tick) begin
        next_state = orp_pkg::ST_V_PULSE;
        next_timer = T_PULSE;
      end
      orp_pkg::ST_V_PULSE: if (tick) begin
        next_state = orp_pkg::ST_V_HOLD;
        next_timer = T_SETUP;
      end
      orp_pkg::ST_V_HOLD: if (tick) begin
        next_state = orp_pkg::ST_V_FLOAT;
        next_timer = T_SETUP;
      end
      orp_pkg::ST_RAMP_DN: if (tick) begin
        next_state = orp_pkg::ST_F_READ;
        next_addr = '0;
        next_timer = T_READ;
      end
      orp_pkg::ST_F_READ: if (tick) begin
        next_state = orp_pkg::ST_F_CMP;
      end
      orp_pkg::ST_F_CMP: begin
        if (!match || last_addr) begin
          next_state = orp_pkg::ST_IDLE;
        end else begin
          next_state = orp_pkg::ST_F_READ;
          next_addr = addr + 1'b1;
          next_timer = T_READ;
        end
      end
      orp_pkg::ST_ID_SET: if (tick) begin
        next_state = orp_pkg::ST_ID_READ;
        next_timer = T_READ;
      end
      orp_pkg::ST_ID_READ: if (tick) begin
        next_state = orp_pkg::ST_IDLE;
      end
      default: begin
        next_state = orp_pkg::ST_IDLE;
      end
    endcase
  end

  // Session verdict; a fail in either loop is final, pass needs the whole reread
  wire verify_fail = (state == orp_pkg::ST_V_CMP) && !match && (retry == orp_pkg::RETRY_MAX);
  wire final_fail = (state == orp_pkg::ST_F_CMP) && !match;
  wire final_pass = (state == orp_pkg::ST_F_CMP) && match && last_addr;
  wire id_done = (state == orp_pkg::ST_ID_READ) && tick;

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      state <= orp_pkg::ST_IDLE;
      timer <= '0;
      addr <= '0;
      retry <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      addr <= next_addr;
      retry <= next_retry;
    end
  end

  // Registered pin controls, so chip select never glitches on state decode
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      drive <= 1'b0;
    end else begin
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      drive <= next_drive;
    end
  end

  // Data pins cross from outside: three stages, a change taken when two agree
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      rd_byte <= '0;
    end else begin
      sync1 <= data_outputs_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        rd_byte <= sync3;
      end
    end
  end

  // Status flags, cleared by the start of a new session
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pass <= 1'b0;
      fail <= 1'b0;
      done <= 1'b0;
      fail_addr <= '0;
      id_data <= '0;
    end else begin
      done <= verify_fail || final_fail || final_pass;
      if (idle && start_in) begin
        pass <= 1'b0;
        fail <= 1'b0;
      end
      if (final_pass) begin
        pass <= 1'b1;
      end
      if (verify_fail || final_fail) begin
        fail <= 1'b1;
        fail_addr <= addr;
      end
      if (id_done) begin
        id_data <= rd_byte;
      end
    end
  end

  assign busy_out = !idle;
  assign done_out = done;
  assign pass_out = pass;
  assign fail_out = fail;
  assign fail_addr_out = fail_addr;
  assign id_data_out = id_data;
  assign rom_addr_out = addr;
  assign rom_ce_n_out = ce_n;
  assign rom_oe_n_out = oe_n;
  assign data_outputs_out = mem_if.rd_data;
  assign data_outputs_oe_out = drive;
  assign vcc_prog_out = in_prog(state);
  assign vpp_prog_out = in_prog(state);
  assign id_mode_address_pin_hv_out = (state == orp_pkg::ST_ID_SET) ||
                                      (state == orp_pkg::ST_ID_READ);

  // Length of the current program pulse, for checking only
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pulse_len <= '0;
    end else if (!ce_n && oe_n) begin
      pulse_len <= pulse_len + 1'b1;
    end else begin
      pulse_len <= '0;
    end
  end

  a_first_addr_zero: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == orp_pkg::ST_RAMP_UP) |-> (addr == '0))
    else $error("session did not start at address zero");
  a_pulse_supplies: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!ce_n && oe_n) |-> (vcc_prog_out && vpp_prog_out))
    else $error("program pulse without programming supplies");
  a_pass1_noread: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state inside {orp_pkg::ST_P1_SET, orp_pkg::ST_P1_PULSE, orp_pkg::ST_P1_HOLD})
    |-> ##1 oe_n)
    else $error("read during first pass");
  a_retry_bound: assert property (@(posedge clock_in) disable iff (!rstn_in)
    retry <= orp_pkg::RETRY_MAX)
    else $error("retry count above limit");
  a_fail_at_limit: assert property (@(posedge clock_in) disable iff (!rstn_in)
    verify_fail |=> (state == orp_pkg::ST_IDLE) ##0 fail && done)
    else $error("tenth retry mismatch did not fail the part");
  a_addr_advance: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state == orp_pkg::ST_V_CMP && match && !last_addr)
    |=> (addr == $past(addr) + 1'b1) && (retry == '0))
    else $error("verify loop did not advance after match");
  a_low_supply_read: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state inside {orp_pkg::ST_RAMP_DN, orp_pkg::ST_F_READ, orp_pkg::ST_F_CMP})
    |-> !vcc_prog_out && !vpp_prog_out)
    else $error("final read-back at programming supplies");
  a_pass_all: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(pass) |-> $past(state == orp_pkg::ST_F_CMP && last_addr && match))
    else $error("pass without complete reread");
  a_pulse_width: assert property (@(posedge clock_in) disable iff (!rstn_in)
    ($rose(ce_n) && $past(oe_n))
    |-> (pulse_len >= PULSE_MIN_CYC) && (pulse_len <= PULSE_MAX_CYC))
    else $error("program pulse width out of range");
  a_id_level: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (!oe_n && state == orp_pkg::ST_ID_READ) |-> id_mode_address_pin_hv_out)
    else $error("code read without id pin raised");
  a_bus_clash: assert property (@(posedge clock_in) disable iff (!rstn_in)
    drive |-> oe_n ##1 (oe_n || !drive))
    else $error("data pins driven while output enable active");

  c_full_pass: cover property (@(posedge clock_in) disable iff (!rstn_in) $rose(pass));
  c_retry_used: cover property (@(posedge clock_in) disable iff (!rstn_in)
    state == orp_pkg::ST_V_PULSE);
  c_part_failed: cover property (@(posedge clock_in) disable iff (!rstn_in) verify_fail);
  c_id_read: cover property (@(posedge clock_in) disable iff (!rstn_in) id_done);
endmodule

// ===== test/orp_programmer_tb_top.sv
/*
  Self-checking bench for the ROM programmer: random images, sessions against the
  ROM model, code reads. Assumes shortened pulse parameters of 19/20/21 cycles.
*/
`timescale 1ns/1ps
module orp_programmer_tb_top;
  localparam int AW = 3;
  localparam int NB = 2**AW;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary
  localparam logic [7:0] DTYPE = 8'hC3; // Arbitrary
  typedef struct {logic is_id; logic [31:0] exp;} orp_note_type;
  logic clock_in, rstn_in = 1'b0, load_valid = 1'b0, start = 1'b0, id_read = 1'b0;
  logic id_sel = 1'b0, new_part = 1'b0, busy_q = 1'b0, fade = 1'b0;
  logic [AW-1:0] load_addr = '0, weak_addr = '0, fail_addr, rom_addr;
  logic [7:0] load_data = 8'h00, id_data, host_d, rom_q;
  logic [7:0] img [NB];
  logic [3:0] weak_need = 4'h1;
  logic load_ready, busy, done, pass, fail, ce_n, oe_n, host_oe, vcc_hi, vpp_hi, hv;
  wire [7:0] data_bus = host_oe ? host_d : rom_q;
  int pulses, bad, seed = 19, n_errors = 0, check_count = 0;
  orp_note_type notes [$];
  orp_note_type got;

  orp_programmer #(.ADDR_W(AW), .PULSE_CYC(20), .PULSE_MIN_CYC(19), .PULSE_MAX_CYC(21)) uut (
    .clock_in(clock_in), .rstn_in(rstn_in), .load_valid_in(load_valid),
    .load_addr_in(load_addr), .load_data_in(load_data), .load_ready_out(load_ready),
    .start_in(start), .id_read_in(id_read), .id_sel_in(id_sel), .busy_out(busy),
    .done_out(done), .pass_out(pass), .fail_out(fail), .fail_addr_out(fail_addr),
    .id_data_out(id_data), .rom_addr_out(rom_addr), .rom_ce_n_out(ce_n),
    .rom_oe_n_out(oe_n), .data_outputs_out(host_d), .data_outputs_oe_out(host_oe),
    .data_outputs_in(data_bus), .vcc_prog_out(vcc_hi), .vpp_prog_out(vpp_hi),
    .id_mode_address_pin_hv_out(hv));
  orp_rom_model #(.AW(AW), .MAKER(MAKER), .DTYPE(DTYPE)) rom (
    .addr_in(rom_addr), .ce_n_in(ce_n), .oe_n_in(oe_n), .bus_in(data_bus),
    .host_oe_in(host_oe), .vcc_hi_in(vcc_hi), .vpp_hi_in(vpp_hi), .hv_in(hv),
    .new_part_in(new_part), .weak_addr_in(weak_addr), .weak_need_in(weak_need),
    .fade_in(fade), .q_out(rom_q), .pulses_out(pulses), .bad_out(bad));

  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  task automatic compare(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, act, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 9000 && busy !== 1'b0; i++) step();
    // A sequence that never ends is a mismatch, not a silent return
    compare({31'h0, busy}, 32'h0);
  endtask
  // Random image; the slow byte is never all ones so it really needs programming
  task automatic load_image(input logic [AW-1:0] w);
    for (int a = 0; a < NB; a++) begin
      img[a] = 8'($random(seed));
      if (a == w) img[a][7] = 1'b0;
      load_valid = 1'b1;
      load_addr = AW'(a);
      load_data = img[a];
      step();
    end
    load_valid = 1'b0;
  endtask
  // Whole session on a blank part; a late load and start must be refused
  task automatic session(input logic [AW-1:0] w, input logic [3:0] need, input logic ok,
                         input int exp_pulses);
    orp_note_type n;
    load_image(w);
    weak_addr = w;
    weak_need = need;
    new_part = 1'b1;
    n.is_id = 1'b0;
    n.exp = {8'(exp_pulses), 8'h00, 8'(ok ? 3'h0 : w), 6'h00, ok, !ok};
    notes.push_back(n);
    start = 1'b1;
    step();
    start = 1'b0;
    new_part = 1'b0;
    step(1950);
    start = 1'b1;
    load_valid = 1'b1;
    load_addr = '0;
    load_data = ~img[0];
    step();
    start = 1'b0;
    load_valid = 1'b0;
    wait_idle();
    $display("session slow byte %0d needing %0d pulses ended", w, need);
  endtask
  task automatic read_code(input logic sel);
    orp_note_type n;
    n.is_id = 1'b1;
    n.exp = {24'h0, sel ? DTYPE : MAKER};
    notes.push_back(n);
    id_read = 1'b1;
    id_sel = sel;
    step();
    id_read = 1'b0;
    wait_idle();
    $display("code read %0d ended", sel);
  endtask

  // Oldest note is compared when a session ends or a code read finishes
  always @(posedge clock_in) begin
    busy_q <= busy;
    if (done === 1'b1 || (busy_q && busy === 1'b0 && notes.size() > 0 && notes[0].is_id)) begin
      if (notes.size() == 0) begin
        compare(32'h1, 32'h0);
      end else begin
        got = notes.pop_front();
        if (got.is_id) compare({24'h0, id_data}, got.exp);
        else compare({8'(pulses), 8'(bad), 8'(fail ? fail_addr : 3'h0), 6'h00, pass, fail},
                     got.exp);
      end
    end
  end
  initial begin
    step(8);
    rstn_in = 1'b1;
    compare(32'({busy, ce_n, oe_n, host_oe, vcc_hi, vpp_hi, load_ready}), 32'h31);
    $display("reset state checked");
    session(AW'($random(seed)), 4'h1, 1'b1, NB);
    session(3'h5, 4'h4, 1'b1, NB + 3);
    session(3'h6, 4'hB, 1'b1, NB + 10);
    session(3'h2, 4'hC, 1'b0, NB + 10);
    fade = 1'b1;
    session(3'h3, 4'h1, 1'b0, NB);
    read_code(1'b0);
    read_code(1'b1);
    step(20);
    compare(32'(notes.size()), 32'h0);
    stop_test();
  end
  // Watchdog sized well above the expected run
  initial begin
    repeat (60000) @(posedge clock_in);
    n_errors++;
    stop_test();
  end
endmodule

// ===== test/orp_rom_model.sv
/*
  Behavioural one-time programmable ROM for the programmer bench.
  Assumes the bench resolves the shared data pins and pulses new_part_in per session.
*/
`timescale 1ns/1ps
module orp_rom_model #(
  parameter int AW = 3,
  parameter logic [7:0] MAKER = 8'h5A, // Arbitrary maker code
  parameter logic [7:0] DTYPE = 8'hC3, // Arbitrary type code
  parameter int PW_MIN_NS = 380,
  parameter int PW_MAX_NS = 420
) (
  input wire logic [AW-1:0] addr_in,      // Address pins
  input wire logic ce_n_in,               // Chip select, low
  input wire logic oe_n_in,               // Output enable, low
  input wire logic [7:0] bus_in,          // Resolved data pins
  input wire logic host_oe_in,            // Programmer drives data
  input wire logic vcc_hi_in,             // Core supply raised
  input wire logic vpp_hi_in,             // Program supply raised
  input wire logic hv_in,                 // Id pin raised
  input wire logic new_part_in,           // Fit a blank part
  input wire logic [AW-1:0] weak_addr_in, // Slow location
  input wire logic [3:0] weak_need_in,    // Pulses it needs
  input wire logic fade_in,               // Slow byte reads bit 0 inverted at 5 V
  output logic [7:0] q_out,               // Data pin drive
  output int pulses_out,                  // Program pulses seen
  output int bad_out                      // Pin misuse count
);
  logic [7:0] mem [2**AW];
  int hits [2**AW];
  time t_fall;
  logic [7:0] d_fall;
  // Both selects rise in one step after a read, in either order; this flag,
  // set while both are low, keeps that edge from counting as a pulse
  logic read_seen = 1'b0;
  initial q_out = 8'h00;
  // A blank part reads all ones
  always @(posedge new_part_in) begin
    foreach (mem[i]) begin
      mem[i] = 8'hFF;
      hits[i] = 0;
    end
    pulses_out = 0;
    bad_out = 0;
  end
  // Data are latched as the pulse starts
  always @(negedge ce_n_in) begin
    t_fall = $time;
    d_fall = bus_in;
  end
  // Program pulse: chip select low while output enable stays high
  always @(posedge ce_n_in) begin
    if (oe_n_in && !read_seen) begin
      if ($time - t_fall < PW_MIN_NS || $time - t_fall > PW_MAX_NS) bad_out++;
      if (!vcc_hi_in || !vpp_hi_in || !host_oe_in) bad_out++;
      if (pulses_out == 0 && addr_in != '0) bad_out++;
      pulses_out++;
      hits[addr_in]++;
      // The slow location only takes its data after enough pulses
      if (addr_in != weak_addr_in || hits[addr_in] >= weak_need_in) begin
        mem[addr_in] &= d_fall;
      end
    end
    read_seen = 1'b0;
  end
  // No pull on the pins, so a released bus shows a changing pattern
  always @(ce_n_in, oe_n_in, addr_in, hv_in, pulses_out, new_part_in) begin
    if (!ce_n_in && !oe_n_in) begin
      read_seen = 1'b1;
      if (host_oe_in) bad_out++;
      // A fading byte verifies at programming supplies but not at 5 V
      q_out = hv_in ? (addr_in[0] ? DTYPE : MAKER) :
              mem[addr_in] ^ {7'h00, fade_in && !vcc_hi_in && addr_in == weak_addr_in};
    end else begin
      q_out = ~q_out;
    end
  end
endmodule
